// ===== pkg/sbp_pkg.sv
// constants for the discovery parameter table block
package sbp_pkg;
    localparam int SBP_AW = 8;
    localparam int SBP_DW = 8;

    // discovery header fields that point at the table
    localparam logic [7:0] SBP_OFS_HDR_LEN = 8'h0B;
    localparam logic [7:0] SBP_OFS_HDR_PTR0 = 8'h0C;
    localparam logic [7:0] SBP_OFS_HDR_PTR1 = 8'h0D;
    localparam logic [7:0] SBP_OFS_HDR_PTR2 = 8'h0E;
    localparam logic [7:0] SBP_HDR_LEN_DWORDS = 8'h10;
    localparam logic [7:0] SBP_HDR_PTR0_VAL = 8'h30;
    localparam logic [7:0] SBP_HDR_PTR_HI_VAL = 8'h00;

    // table offsets
    localparam logic [7:0] SBP_OFS_PARAM_FEATURES_BYTE0 = 8'h30;
    localparam logic [7:0] SBP_OFS_SECTOR_ERASE_OPCODE = 8'h31;
    localparam logic [7:0] SBP_OFS_READ_MODE_SUPPORT = 8'h32;
    localparam logic [7:0] SBP_OFS_PARAM_UNUSED_UPPER = 8'h33;
    localparam logic [7:0] SBP_OFS_ARRAY_DENSITY_BITS = 8'h34;
    localparam logic [7:0] SBP_OFS_QUAD_IO_CYCLE_COUNTS = 8'h38;
    localparam logic [7:0] SBP_OFS_QUAD_IO_READ_OPCODE = 8'h39;
    localparam logic [7:0] SBP_OFS_QUAD_OUT_CYCLE_COUNTS = 8'h3A;
    localparam logic [7:0] SBP_OFS_QUAD_OUT_READ_OPCODE = 8'h3B;
    localparam logic [7:0] SBP_OFS_DUAL_OUT_CYCLE_COUNTS = 8'h3C;
    localparam logic [7:0] SBP_OFS_DUAL_OUT_READ_OPCODE = 8'h3D;
    localparam logic [7:0] SBP_OFS_DUAL_IO_CYCLE_COUNTS = 8'h3E;
    localparam logic [7:0] SBP_OFS_DUAL_IO_READ_OPCODE = 8'h3F;

    // block's own registers
    localparam logic [7:0] SBP_OFS_DENSITY_SEL = 8'h80;
    localparam logic [7:0] SBP_OFS_IGNORED_WRITES = 8'h81;

    // table values
    localparam logic [7:0] SBP_VAL_PARAM_FEATURES_BYTE0 = 8'hE5;
    localparam logic [7:0] SBP_VAL_SECTOR_ERASE_OPCODE = 8'h20;
    localparam logic [7:0] SBP_VAL_READ_MODE_SUPPORT = 8'hF1;
    localparam logic [7:0] SBP_VAL_PARAM_UNUSED_UPPER = 8'hFF;
    localparam logic [7:0] SBP_VAL_QUAD_IO_CYCLE_COUNTS = 8'h44;
    localparam logic [7:0] SBP_VAL_QUAD_IO_READ_OPCODE = 8'hEB;
    localparam logic [7:0] SBP_VAL_QUAD_OUT_CYCLE_COUNTS = 8'h08;
    localparam logic [7:0] SBP_VAL_QUAD_OUT_READ_OPCODE = 8'h6B;
    localparam logic [7:0] SBP_VAL_DUAL_OUT_CYCLE_COUNTS = 8'h08;
    localparam logic [7:0] SBP_VAL_DUAL_OUT_READ_OPCODE = 8'h3B;
    localparam logic [7:0] SBP_VAL_DUAL_IO_CYCLE_COUNTS = 8'h80;
    localparam logic [7:0] SBP_VAL_DUAL_IO_READ_OPCODE = 8'hBB;
    localparam logic [7:0] SBP_VAL_UNMAPPED = 8'hFF;

    // density in bits minus one, per part size
    localparam logic [31:0] SBP_DENS_2MBIT = 32'h001FFFFF;
    localparam logic [31:0] SBP_DENS_4MBIT = 32'h003FFFFF;
    localparam logic [31:0] SBP_DENS_8MBIT = 32'h007FFFFF;

    // density select encodings
    localparam logic [1:0] SBP_DSEL_2MBIT = 2'h0;
    localparam logic [1:0] SBP_DSEL_4MBIT = 2'h1;
    localparam logic [1:0] SBP_DSEL_8MBIT = 2'h2;
    localparam logic [1:0] SBP_DSEL_RESET = SBP_DSEL_8MBIT;

    // field positions in the first parameter byte and byte 32h
    localparam int SBP_FB_ERASE_LSB = 0;
    localparam int SBP_FB_PROG_BUF = 2;
    localparam int SBP_FB_VOLSTAT_LSB = 3;
    localparam int SBP_RM_DDR = 3;
    localparam int SBP_RM_ADDR_LSB = 1;
endpackage

// ===== rtl/sbp_param_table.sv
// read-only discovery parameter table with register port and byte stream
// Function
// - byte 30h reads E5h, top bits ones
// - first byte bits 4:3 read 00b
// - first byte bit 2 reads one
// - first byte bits 1:0 read 01b
// - byte 31h reports erase opcode 20h
// - byte 32h reads F1h
// - double-rate support bit 19 reads zero
// - address bytes field reads 00b, three-byte
// - byte 33h reads FFh
// - bytes 34h-37h give density bits minus one
// - byte 38h reads 44h
// - byte 39h reports opcode EBh
// - byte 3Ah reads 08h
// - byte 3Bh reports opcode 6Bh
// - byte 3Ch reads 08h
// - byte 3Dh reports opcode 3Bh
// - byte 3Eh reads 80h
// - byte 3Fh reports opcode BBh
// - header points to table at 30h
// - header gives table length 10h dwords
//
// The address-and-strobe port is this design's own decision.
module sbp_param_table (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [sbp_pkg::SBP_AW-1:0] reg_addr,
    input wire logic [sbp_pkg::SBP_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [sbp_pkg::SBP_DW-1:0] reg_rdata,
    input wire logic disc_load,
    input wire logic [sbp_pkg::SBP_AW-1:0] disc_addr,
    input wire logic disc_next,
    output logic [sbp_pkg::SBP_DW-1:0] disc_data,
    output logic disc_valid
);
    import sbp_pkg::*;

    typedef struct packed {
        logic [7:0] rd_data;
        logic [7:0] ptr;
        logic [7:0] disc_data;
        logic disc_valid;
        logic [1:0] dens_sel;
        logic [7:0] ign_cnt;
    } sbp_state_s;

    sbp_state_s st_r;
    sbp_state_s st_nxt;

    function automatic logic [31:0] sbp_density(input logic [1:0] ds);
        logic [31:0] d;
        d = SBP_DENS_8MBIT;
        if (ds == SBP_DSEL_2MBIT) begin
            d = SBP_DENS_2MBIT;
        end else if (ds == SBP_DSEL_4MBIT) begin
            d = SBP_DENS_4MBIT;
        end
        return d;
    endfunction

    // one byte of discovery space; constants, except bytes 34h-37h, which follow the density select
    function automatic logic [7:0] sbp_rom(input logic [7:0] a, input logic [1:0] ds);
        logic [31:0] dens;
        logic [7:0] b;
        dens = sbp_density(ds);
        b = SBP_VAL_UNMAPPED;
        case (a)
            SBP_OFS_HDR_LEN: b = SBP_HDR_LEN_DWORDS;
            SBP_OFS_HDR_PTR0: b = SBP_HDR_PTR0_VAL;
            SBP_OFS_HDR_PTR1: b = SBP_HDR_PTR_HI_VAL;
            SBP_OFS_HDR_PTR2: b = SBP_HDR_PTR_HI_VAL;
            SBP_OFS_PARAM_FEATURES_BYTE0: b = SBP_VAL_PARAM_FEATURES_BYTE0;
            SBP_OFS_SECTOR_ERASE_OPCODE: b = SBP_VAL_SECTOR_ERASE_OPCODE;
            SBP_OFS_READ_MODE_SUPPORT: b = SBP_VAL_READ_MODE_SUPPORT;
            SBP_OFS_PARAM_UNUSED_UPPER: b = SBP_VAL_PARAM_UNUSED_UPPER;
            8'h34: b = dens[7:0];
            8'h35: b = dens[15:8];
            8'h36: b = dens[23:16];
            8'h37: b = dens[31:24];
            SBP_OFS_QUAD_IO_CYCLE_COUNTS: b = SBP_VAL_QUAD_IO_CYCLE_COUNTS;
            SBP_OFS_QUAD_IO_READ_OPCODE: b = SBP_VAL_QUAD_IO_READ_OPCODE;
            SBP_OFS_QUAD_OUT_CYCLE_COUNTS: b = SBP_VAL_QUAD_OUT_CYCLE_COUNTS;
            SBP_OFS_QUAD_OUT_READ_OPCODE: b = SBP_VAL_QUAD_OUT_READ_OPCODE;
            SBP_OFS_DUAL_OUT_CYCLE_COUNTS: b = SBP_VAL_DUAL_OUT_CYCLE_COUNTS;
            SBP_OFS_DUAL_OUT_READ_OPCODE: b = SBP_VAL_DUAL_OUT_READ_OPCODE;
            SBP_OFS_DUAL_IO_CYCLE_COUNTS: b = SBP_VAL_DUAL_IO_CYCLE_COUNTS;
            SBP_OFS_DUAL_IO_READ_OPCODE: b = SBP_VAL_DUAL_IO_READ_OPCODE;
            default: b = SBP_VAL_UNMAPPED;
        endcase
        return b;
    endfunction

    always_comb begin
        st_nxt = st_r;
        st_nxt.disc_valid = 1'b0;
        if (reg_rd) begin
            if (reg_addr == SBP_OFS_DENSITY_SEL) begin
                st_nxt.rd_data = {6'h00, st_r.dens_sel};
            end else if (reg_addr == SBP_OFS_IGNORED_WRITES) begin
                st_nxt.rd_data = st_r.ign_cnt;
            end else begin
                st_nxt.rd_data = sbp_rom(reg_addr, st_r.dens_sel);
            end
        end
        if (reg_wr) begin
            if (reg_addr == SBP_OFS_DENSITY_SEL) begin
                st_nxt.dens_sel = reg_wdata[1:0];
            end else if (reg_addr != SBP_OFS_IGNORED_WRITES) begin
                // table writes are dropped but counted
                st_nxt.ign_cnt = st_r.ign_cnt + 8'h01;
            end
        end
        // load takes precedence over next
        if (disc_load) begin
            st_nxt.disc_data = sbp_rom(disc_addr, st_r.dens_sel);
            st_nxt.ptr = disc_addr + 8'h01;
            st_nxt.disc_valid = 1'b1;
        end else if (disc_next) begin
            st_nxt.disc_data = sbp_rom(st_r.ptr, st_r.dens_sel);
            st_nxt.ptr = st_r.ptr + 8'h01;
            st_nxt.disc_valid = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '{rd_data: 8'h00, ptr: 8'h00, disc_data: 8'h00, disc_valid: 1'b0,
                      dens_sel: SBP_DSEL_RESET, ign_cnt: 8'h00};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rd_data;
    assign disc_data = st_r.disc_data;
    assign disc_valid = st_r.disc_valid;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    AST_BYTE30: assert property (reg_rd && reg_addr == 8'h30 |=> reg_rdata == 8'hE5 && reg_rdata[7:5] == 3'h7)
        else $error("byte 30h wrong");
    AST_VOLSTAT: assert property (reg_rd && reg_addr == 8'h30 |=> reg_rdata[4:3] == 2'h0)
        else $error("status write field wrong");
    AST_PROGBUF: assert property (reg_rd && reg_addr == 8'h30 |=> reg_rdata[2])
        else $error("program buffer bit wrong");
    AST_ERASE4K: assert property (reg_rd && reg_addr == 8'h30 |=> reg_rdata[1:0] == 2'h1)
        else $error("erase field wrong");
    AST_ERASEOP: assert property (reg_rd && reg_addr == 8'h31 |=> reg_rdata == 8'h20)
        else $error("erase opcode wrong");
    AST_MODES: assert property (reg_rd && reg_addr == 8'h32 |=> reg_rdata == 8'hF1)
        else $error("read mode byte wrong");
    AST_NODDR: assert property (reg_rd && reg_addr == 8'h32 |=> !reg_rdata[3])
        else $error("ddr bit set");
    AST_ADDR3: assert property (reg_rd && reg_addr == 8'h32 |=> reg_rdata[2:1] == 2'h0)
        else $error("address width field wrong");
    AST_UPPER: assert property (reg_rd && reg_addr == 8'h33 |=> reg_rdata == 8'hFF)
        else $error("byte 33h wrong");
    AST_DENS8: assert property (reg_rd && reg_addr == 8'h36 && st_r.dens_sel == 2'h2 |=> reg_rdata == 8'h7F)
        else $error("density byte wrong");
    AST_QIOCYC: assert property (reg_rd && reg_addr == 8'h38 |=> reg_rdata == 8'h44)
        else $error("quad io cycles wrong");
    AST_QIOOP: assert property (reg_rd && reg_addr == 8'h39 |=> reg_rdata == 8'hEB)
        else $error("quad io opcode wrong");
    AST_QOCYC: assert property (reg_rd && reg_addr == 8'h3A |=> reg_rdata == 8'h08)
        else $error("quad out cycles wrong");
    AST_QOOP: assert property (reg_rd && reg_addr == 8'h3B |=> reg_rdata == 8'h6B)
        else $error("quad out opcode wrong");
    AST_DOCYC: assert property (reg_rd && reg_addr == 8'h3C |=> reg_rdata == 8'h08)
        else $error("dual out cycles wrong");
    AST_DOOP: assert property (reg_rd && reg_addr == 8'h3D |=> reg_rdata == 8'h3B)
        else $error("dual out opcode wrong");
    AST_DIOCYC: assert property (reg_rd && reg_addr == 8'h3E |=> reg_rdata == 8'h80)
        else $error("dual io cycles wrong");
    AST_DIOOP: assert property (reg_rd && reg_addr == 8'h3F |=> reg_rdata == 8'hBB)
        else $error("dual io opcode wrong");
    AST_HDRPTR: assert property (reg_rd && reg_addr == 8'h0C |=> reg_rdata == 8'h30)
        else $error("header pointer wrong");
    AST_HDRLEN: assert property (reg_rd && reg_addr == 8'h0B |=> reg_rdata == 8'h10)
        else $error("header length wrong");
    AST_STREAM: assert property (disc_next && !disc_load && st_r.ptr == 8'h31
                                 |=> disc_valid && disc_data == 8'h20)
        else $error("stream did not advance");
    AST_RO: assert property (reg_wr && reg_addr != 8'h80 |=> st_r.dens_sel == $past(st_r.dens_sel))
        else $error("table setting changed by write");

    COV_STREAM4: cover property (disc_load ##2 disc_next ##2 disc_next);
    COV_DSEL2: cover property (reg_wr && reg_addr == 8'h80 && reg_wdata[1:0] == 2'h0 ##4 reg_rd && reg_addr == 8'h36);
    COV_IGNWR: cover property (reg_wr && reg_addr == 8'h81);
endmodule

// ===== tb/sbp_host_model.sv
// host controller model reading the discovery byte stream
module sbp_host_model (
    input wire logic clk,
    input wire logic [7:0] disc_data,
    input wire logic disc_valid,
    output logic disc_load,
    output logic [7:0] disc_addr,
    output logic disc_next
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got [16];
    initial begin
        disc_load = 1'b0;
        disc_next = 1'b0;
        disc_addr = 8'h00;
    end
    // load first, then one next per byte after the first; gap sets how slowly the host asks
    task automatic stream(input logic [7:0] a, input int len, input int gap);
        int k;
        @(posedge clk);
        disc_load <= 1'b1; // host starts at the address a that the caller gives
        disc_addr <= a;
        @(posedge clk);
        disc_load <= 1'b0;
        for (int i = 0; i < len; i++) begin
            k = 0;
            // values read at the edge are those that stood in the cycle before it
            do begin
                @(posedge clk);
                k++;
            end while (disc_valid !== 1'b1 && k < 20);
            got[i] = (disc_valid === 1'b1) ? disc_data : 8'hXX;
            if (i < len - 1) begin
                repeat (gap) @(posedge clk);
                disc_next <= 1'b1;
                @(posedge clk);
                disc_next <= 1'b0;
            end
        end
    endtask
endmodule

// ===== tb/sbp_param_table_tb.sv
// self-checking bench for the discovery parameter table
module sbp_param_table_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sbp_pkg::*;
    logic clk, arst_n, reg_wr, reg_rd, disc_load, disc_next, disc_valid;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, disc_addr, disc_data, v;
    int error_cnt, tests_run;
    logic [7:0] exp_t [16] = '{8'hE5, 8'h20, 8'hF1, 8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'h00,
                               8'h44, 8'hEB, 8'h08, 8'h6B, 8'h08, 8'h3B, 8'h80, 8'hBB};
    logic [7:0] dsel_t [4] = '{8'h00, 8'h01, 8'h03, 8'h02};
    logic [7:0] dens_t [4] = '{8'h1F, 8'h3F, 8'h7F, 8'h7F};

    sbp_param_table dut_u (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .disc_load(disc_load),
        .disc_addr(disc_addr), .disc_next(disc_next), .disc_data(disc_data), .disc_valid(disc_valid));
    sbp_host_model host_u (.clk(clk), .disc_data(disc_data), .disc_valid(disc_valid),
        .disc_load(disc_load), .disc_addr(disc_addr), .disc_next(disc_next));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        tests_run++;
        if (s !== e) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic end_of_test();
        if (error_cnt == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        #100us;
        error_cnt++;
        end_of_test();
    end

    initial begin
        arst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        #1 chk(reg_rdata, 8'h00);
        chk({7'h00, disc_valid}, 8'h00);
        for (int i = 0; i < 16; i++) begin
            rd(8'h30 + i[7:0], v);
            chk(v, exp_t[i]);
        end
        rd(8'h30, v);
        chk({5'h00, v[7:5]}, 8'h07);
        chk({6'h00, v[4:3]}, 8'h00);
        chk({7'h00, v[2]}, 8'h01);
        chk({6'h00, v[1:0]}, 8'h01);
        rd(8'h32, v);
        chk({7'h00, v[3]}, 8'h00);
        chk({6'h00, v[2:1]}, 8'h00);
        rd(8'h0B, v);
        chk(v, 8'h10);
        rd(8'h0C, v);
        chk(v, 8'h30);
        rd(8'h0D, v);
        chk(v, 8'h00);
        rd(8'h0E, v);
        chk(v, 8'h00);
        rd(8'h90, v);
        chk(v, 8'hFF);
        // writes into the table are dropped and only counted
        wr(8'h30, 8'h00);
        wr(8'h3F, 8'h12);
        rd(8'h30, v);
        chk(v, 8'hE5);
        rd(8'h3F, v);
        chk(v, 8'hBB);
        for (int i = 0; i < 4; i++) begin
            wr(8'h80, dsel_t[i]);
            rd(8'h80, v);
            chk(v, dsel_t[i]);
            rd(8'h36, v);
            chk(v, dens_t[i]);
        end
        rd(8'h81, v);
        chk(v, 8'h02);
        wr(8'h81, 8'h55);
        rd(8'h81, v);
        chk(v, 8'h02);
        // reset in mid-run brings density select and write count back
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        rd(8'h80, v);
        chk(v, 8'h02);
        rd(8'h81, v);
        chk(v, 8'h00);
        rd(8'h36, v);
        chk(v, 8'h7F);
        host_u.stream(8'h30, 16, 0);
        for (int i = 0; i < 16; i++)
            chk(host_u.got[i], exp_t[i]);
        host_u.stream(8'h2F, 6, 3);
        chk(host_u.got[0], 8'hFF);
        for (int i = 1; i < 6; i++)
            chk(host_u.got[i], exp_t[i - 1]);
        end_of_test();
    end
endmodule
